// ---- hw/pgw_params.svh ----
/*
  Constants for the polled I/O gateway: command codes, field positions,
  status and reply codes and the explicit command address.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PGW_PARAMS_SVH
`define PGW_PARAMS_SVH

`define PGW_CMD_SAFE      8'h00
`define PGW_CMD_VALID     8'h14
`define PGW_CMD_RUN       8'h34
`define PGW_CMD_STOP      8'h44
`define PGW_STATUS_BAD    8'h04
`define PGW_UNUSED_BYTE   8'h00
`define PGW_ZERO_BYTE     8'h00
`define PGW_RUN_BIT       0
`define PGW_NODELAY_BIT   4
`define PGW_DELAY_BIT     5
`define PGW_SVC_CODE      8'h32
`define PGW_OBJ_A         8'h64
`define PGW_OBJ_B         8'h01
`define PGW_RESP_OK       8'hC1
`define PGW_RESP_REJECT   8'hC0
`define PGW_ERR_ADDR      8'h16

`endif

// ---- hw/pgw_pkg.sv ----
/*
  Types shared by the polled I/O gateway modules.
  Assumes nothing of its surroundings.
*/
package pgw_pkg;
  typedef enum logic [1:0] {
    PGW_IDLE = 2'b00,
    PGW_BUSY = 2'b01,
    PGW_RESP = 2'b10
  } pgw_state_t;
endpackage

// ---- hw/pgw_cmd_if.sv ----
/*
  Interface between the gateway top and its explicit command tracker.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface pgw_cmd_if;
  logic       busy;
  logic       done;
  modport tracker (output busy, output done);
  modport user    (input  busy, input  done);
endinterface

// ---- hw/pgw_cmd_track.sv ----
/*
  Explicit command tracker: checks the address of a request, holds busy
  while the data exchange runs, then returns one reply.
  Assumes request and end strobes are one-cycle pulses on clk.
*/
`timescale 1ns/1ns
`include "pgw_params.svh"
module pgw_cmd_track (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Request from the explicit message layer
  input  wire logic       req_valid,
  input  wire logic [7:0] req_service,
  input  wire logic [7:0] req_object_a,
  input  wire logic [7:0] req_object_b,
  input  wire logic       xchg_end,
  input  wire logic       xchg_ok,
  // Reply
  output logic            rsp_valid,
  output logic [7:0]      rsp_code,
  output logic            rsp_error,
  // Status to the gateway
  pgw_cmd_if.tracker      cmd
);
  pgw_pkg::pgw_state_t state_reg, state_next;
  logic [7:0] code_reg, code_next;
  logic       err_reg, err_next;
  logic       addr_ok;

  assign addr_ok = req_service == `PGW_SVC_CODE &&
                   req_object_a == `PGW_OBJ_A &&
                   req_object_b == `PGW_OBJ_B;

  always_comb begin
    state_next = state_reg;
    code_next  = code_reg;
    err_next   = err_reg;
    case (state_reg)
      pgw_pkg::PGW_IDLE: begin
        if (req_valid && addr_ok) begin
          state_next = pgw_pkg::PGW_BUSY;
        end else if (req_valid) begin
          state_next = pgw_pkg::PGW_RESP;
          code_next  = `PGW_RESP_REJECT;
          err_next   = 1'b1;
        end
      end
      pgw_pkg::PGW_BUSY: begin
        if (xchg_end) begin
          state_next = pgw_pkg::PGW_RESP;
          code_next  = xchg_ok ? `PGW_RESP_OK : `PGW_RESP_REJECT;
          err_next   = !xchg_ok;
        end
      end
      default: begin
        state_next = pgw_pkg::PGW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= pgw_pkg::PGW_IDLE;
      code_reg  <= 8'h00;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      code_reg  <= code_next;
      err_reg   <= err_next;
    end
  end

  assign cmd.busy  = state_reg == pgw_pkg::PGW_BUSY;
  assign cmd.done  = state_reg == pgw_pkg::PGW_RESP;
  assign rsp_valid = state_reg == pgw_pkg::PGW_RESP;
  assign rsp_code  = code_reg;
  assign rsp_error = err_reg;

  a_reply_follows_end: assert property (@(posedge clk) disable iff (rst)
    state_reg == pgw_pkg::PGW_BUSY && xchg_end |=> rsp_valid)
    else $error("no reply after exchange end");
  a_bad_addr_reject: assert property (@(posedge clk) disable iff (rst)
    state_reg == pgw_pkg::PGW_IDLE && req_valid && !addr_ok
    |=> rsp_valid && rsp_error)
    else $error("misaddressed request not rejected");
endmodule

// ---- hw/pgw_gateway.sv ----
/*
  Polled I/O gateway top: maps three output bytes from the master onto
  remote input bits and run state, and builds three input bytes back.
  Assumes cyclic bytes arrive with a one-cycle frame strobe on clk.
*/
// Operation
// - Three input bytes; third always zero.
// - Byte 0 bit 0 reports RUN.
// - Bit 4 no delay, bit 5 delay.
// - Byte 1 carries remote output bits.
// - Invalid coupling status sends byte 1 zero.
// - Input bytes freeze during explicit command.
// - Code 14 hex accepts data bytes.
// - Code 34 hex sets RUN, no data.
// - Code 44 hex sets STOP, no data.
// - Code 00 hex clears all remote inputs.
// - Byte 1 drives remote inputs 9-16.
// - Byte 2 drives remote inputs 1-8.
// - Remote inputs held during pending command.
// - Commands addressed by service, object a, b.
// - Every command request made while idle receives one reply.
`timescale 1ns/1ns
`include "pgw_params.svh"
module pgw_gateway (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Cyclic output frame from the master
  input  wire logic        out_frame_valid,
  input  wire logic [7:0]  out_byte0,
  input  wire logic [7:0]  out_byte1,
  input  wire logic [7:0]  out_byte2,
  // Base unit status
  input  wire logic [7:0]  remote_output_bits,
  input  wire logic        unit_has_delay,
  input  wire logic [7:0]  coupling_status,
  // Explicit command request
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_service,
  input  wire logic [7:0]  req_object_a,
  input  wire logic [7:0]  req_object_b,
  input  wire logic [7:0]  parameter_selector,
  input  wire logic        xchg_end,
  input  wire logic        xchg_ok,
  // Explicit command reply
  output logic             rsp_valid,
  output logic [7:0]       rsp_code,
  output logic             rsp_error,
  output logic             cmd_busy,
  output logic [7:0]       cmd_selector,
  // Cyclic input bytes to the master
  output logic [7:0]       in_byte0,
  output logic [7:0]       in_byte1,
  output logic [7:0]       in_byte2,
  // Drive to the base unit
  output logic [15:0]      remote_input_bits,
  output logic             run_mode
);
  pgw_cmd_if cmd ();

  logic [15:0] rin_reg, rin_next;
  logic        run_reg, run_next;
  logic [7:0]  ib0_reg, ib0_next;
  logic [7:0]  ib1_reg, ib1_next;
  logic [7:0]  sel_reg, sel_next;
  logic [7:0]  variant;

  // Pending frame, applied once the running command ends if no new frame arrives in that cycle.
  logic        pend_reg, pend_next;
  logic [7:0]  pb0_reg, pb0_next;
  logic [7:0]  pb1_reg, pb1_next;
  logic [7:0]  pb2_reg, pb2_next;

  logic        apply;
  logic [7:0]  ab0, ab1, ab2;

  // Decodes shared by the command and input byte paths and their checks.
  function automatic logic pgw_known(input logic [7:0] code);
    pgw_known = code == `PGW_CMD_SAFE || code == `PGW_CMD_VALID ||
                code == `PGW_CMD_RUN || code == `PGW_CMD_STOP;
  endfunction

  function automatic logic pgw_status_bad(input logic [7:0] status);
    pgw_status_bad = status == `PGW_STATUS_BAD;
  endfunction

  pgw_cmd_track u_track (
    .clk          (clk),
    .rst          (rst),
    .req_valid    (req_valid),
    .req_service  (req_service),
    .req_object_a (req_object_a),
    .req_object_b (req_object_b),
    .xchg_end     (xchg_end),
    .xchg_ok      (xchg_ok),
    .rsp_valid    (rsp_valid),
    .rsp_code     (rsp_code),
    .rsp_error    (rsp_error),
    .cmd          (cmd.tracker)
  );

  always_comb begin
    variant = 8'h00;
    variant[`PGW_NODELAY_BIT] = !unit_has_delay;
    variant[`PGW_DELAY_BIT]   = unit_has_delay;
  end

  // A frame is applied directly while no command is busy, otherwise it waits.
  always_comb begin
    pend_next = pend_reg;
    pb0_next  = pb0_reg;
    pb1_next  = pb1_reg;
    pb2_next  = pb2_reg;
    apply     = 1'b0;
    ab0       = out_byte0;
    ab1       = out_byte1;
    ab2       = out_byte2;
    if (cmd.busy) begin
      if (out_frame_valid) begin
        pend_next = 1'b1;
        pb0_next  = out_byte0;
        pb1_next  = out_byte1;
        pb2_next  = out_byte2;
      end
    end else if (out_frame_valid) begin
      apply     = 1'b1;
      pend_next = 1'b0;
    end else if (pend_reg) begin
      apply     = 1'b1;
      ab0       = pb0_reg;
      ab1       = pb1_reg;
      ab2       = pb2_reg;
      pend_next = 1'b0;
    end
  end

  always_comb begin
    rin_next = rin_reg;
    run_next = run_reg;
    if (apply && pgw_known(ab0)) begin
      case (ab0)
        `PGW_CMD_VALID: rin_next = {ab1, ab2};
        `PGW_CMD_RUN:   run_next = 1'b1;
        `PGW_CMD_STOP:  run_next = 1'b0;
        `PGW_CMD_SAFE:  rin_next = 16'h0000;
        default:        rin_next = rin_reg;
      endcase
    end
  end

  // Input bytes only track the unit while no command is running.
  always_comb begin
    ib0_next = ib0_reg;
    ib1_next = ib1_reg;
    sel_next = sel_reg;
    if (req_valid && !cmd.busy && !cmd.done) begin
      sel_next = parameter_selector;
    end
    if (!cmd.busy) begin
      ib0_next = variant;
      ib0_next[`PGW_RUN_BIT] = run_reg;
      if (pgw_status_bad(coupling_status)) begin
        ib1_next = `PGW_ZERO_BYTE;
      end else begin
        ib1_next = remote_output_bits;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rin_reg  <= 16'h0000;
      run_reg  <= 1'b0;
      ib0_reg  <= 8'h00;
      ib1_reg  <= 8'h00;
      sel_reg  <= 8'h00;
      pend_reg <= 1'b0;
      pb0_reg  <= 8'h00;
      pb1_reg  <= 8'h00;
      pb2_reg  <= 8'h00;
    end else begin
      rin_reg  <= rin_next;
      run_reg  <= run_next;
      ib0_reg  <= ib0_next;
      ib1_reg  <= ib1_next;
      sel_reg  <= sel_next;
      pend_reg <= pend_next;
      pb0_reg  <= pb0_next;
      pb1_reg  <= pb1_next;
      pb2_reg  <= pb2_next;
    end
  end

  assign in_byte0          = ib0_reg;
  assign in_byte1          = ib1_reg;
  assign in_byte2          = `PGW_UNUSED_BYTE;
  assign remote_input_bits = rin_reg;
  assign run_mode          = run_reg;
  assign cmd_busy          = cmd.busy;
  assign cmd_selector      = sel_reg;

  sequence s_frame(logic [7:0] code);
    out_frame_valid && !cmd.busy && out_byte0 == code;
  endsequence

  sequence s_stray;
    out_frame_valid && !cmd.busy && !pgw_known(out_byte0);
  endsequence

  sequence s_park;
    out_frame_valid && cmd.busy;
  endsequence

  sequence s_release(logic [7:0] code);
    pend_reg && !cmd.busy && !out_frame_valid && pb0_reg == code;
  endsequence

  // Frames applied at once.
  a_valid_loads: assert property (@(posedge clk) disable iff (rst)
    s_frame(`PGW_CMD_VALID) |=> remote_input_bits ==
      {$past(out_byte1), $past(out_byte2)})
    else $error("valid frame not applied");
  a_valid_run_keep: assert property (@(posedge clk) disable iff (rst)
    s_frame(`PGW_CMD_VALID) |=> $stable(run_mode))
    else $error("data frame changed run state");
  a_run_cmd: assert property (@(posedge clk) disable iff (rst)
    s_frame(`PGW_CMD_RUN) |=> run_mode && $stable(remote_input_bits))
    else $error("run command misapplied");
  a_stop_cmd: assert property (@(posedge clk) disable iff (rst)
    s_frame(`PGW_CMD_STOP) |=> !run_mode && $stable(remote_input_bits))
    else $error("stop command misapplied");
  a_safe_clear: assert property (@(posedge clk) disable iff (rst)
    s_frame(`PGW_CMD_SAFE) |=> remote_input_bits == 16'h0000)
    else $error("safe code did not clear inputs");
  a_safe_run_keep: assert property (@(posedge clk) disable iff (rst)
    s_frame(`PGW_CMD_SAFE) |=> $stable(run_mode))
    else $error("safe code changed run state");
  a_stray_code: assert property (@(posedge clk) disable iff (rst)
    s_stray |=> $stable(remote_input_bits) && $stable(run_mode))
    else $error("unknown code changed state");
  a_idle_keep: assert property (@(posedge clk) disable iff (rst)
    !rst && !apply |=> $stable(remote_input_bits) && $stable(run_mode))
    else $error("state changed without a frame");

  // Frames parked behind a running command.
  a_park_frame: assert property (@(posedge clk) disable iff (rst)
    s_park |=> pend_reg && pb0_reg == $past(out_byte0))
    else $error("frame during command not parked");
  a_park_apply: assert property (@(posedge clk) disable iff (rst)
    s_release(`PGW_CMD_VALID) |=> remote_input_bits ==
      {$past(pb1_reg), $past(pb2_reg)})
    else $error("parked data frame not applied");
  a_park_safe: assert property (@(posedge clk) disable iff (rst)
    s_release(`PGW_CMD_SAFE) |=> remote_input_bits == 16'h0000)
    else $error("parked safe code not applied");
  a_park_run: assert property (@(posedge clk) disable iff (rst)
    s_release(`PGW_CMD_RUN) |=> run_mode)
    else $error("parked run command not applied");
  a_pend_drain: assert property (@(posedge clk) disable iff (rst)
    !rst && !cmd.busy |=> !pend_reg)
    else $error("parked frame left behind");
  a_hold_busy: assert property (@(posedge clk) disable iff (rst)
    cmd.busy |=> $stable(remote_input_bits) && $stable(run_mode))
    else $error("remote inputs changed during command");

  // Cyclic input bytes.
  a_freeze_in: assert property (@(posedge clk) disable iff (rst)
    cmd.busy |=> $stable(in_byte0) && $stable(in_byte1))
    else $error("input bytes changed during command");
  a_bad_status: assert property (@(posedge clk) disable iff (rst)
    !cmd.busy && pgw_status_bad(coupling_status) |=> in_byte1 == 8'h00)
    else $error("invalid status did not zero byte 1");
  a_status_track: assert property (@(posedge clk) disable iff (rst)
    !rst && !cmd.busy && !pgw_status_bad(coupling_status)
    |=> in_byte1 == $past(remote_output_bits))
    else $error("byte 1 does not follow the unit outputs");
  a_unused_zero: assert property (@(posedge clk) disable iff (rst)
    in_byte2 == 8'h00 && in_byte0[7:6] == 2'b00)
    else $error("unused bits not zero");
  a_variant_code: assert property (@(posedge clk) disable iff (rst)
    !rst && !cmd.busy
    |=> in_byte0[7:1] == ($past(unit_has_delay) ? 7'h10 : 7'h08))
    else $error("variant bits wrong");
  a_run_report: assert property (@(posedge clk) disable iff (rst)
    !rst && !cmd.busy |=> in_byte0[0] == $past(run_mode)
      && in_byte0[5] == $past(unit_has_delay))
    else $error("mode byte wrong");

  // Explicit command hand-off and reset.
  a_sel_capture: assert property (@(posedge clk) disable iff (rst)
    req_valid && !cmd.busy && !cmd.done
    |=> cmd_selector == $past(parameter_selector))
    else $error("selector not captured");
  a_rsp_once: assert property (@(posedge clk) disable iff (rst)
    rsp_valid |=> !rsp_valid)
    else $error("reply longer than one cycle");
  a_reset_clear: assert property (@(posedge clk)
    rst |=> remote_input_bits == 16'h0000 && !run_mode)
    else $error("reset did not clear remote inputs");
endmodule

// ---- testbench/pgw_master_model.sv ----
/*
  Model of the polled master: sends one cyclic frame a cycle after send.
  Assumes the gateway clock; bytes are scrambled between frames.
*/
`timescale 1ns/1ns
module pgw_master_model (
  // Clock and request from the bench
  input  wire logic       clk,
  input  wire logic       send,
  input  wire logic [7:0] cmd,
  input  wire logic [7:0] hi,
  input  wire logic [7:0] lo,
  // Cyclic output frame
  output logic            frame_valid = 1'b0,
  output logic [7:0]      byte0       = 8'h00,
  output logic [7:0]      byte1       = 8'h00,
  output logic [7:0]      byte2       = 8'h00
);
  // Stale bytes are inverted so that only a framed value can match.
  always_ff @(posedge clk) begin
    frame_valid <= send;
    byte0       <= send ? cmd : ~byte0;
    byte1       <= send ? hi : ~byte1;
    byte2       <= send ? lo : ~byte2;
  end
endmodule

// ---- testbench/tb_pgw_gateway.sv ----
/*
  Self-checking bench for the polled I/O gateway.
  Assumes the master model drives the cyclic frame inputs.
*/
`timescale 1ns/1ns
`include "pgw_params.svh"
module tb_pgw_gateway;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        send = 1'b0;
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  hi = 8'h00;
  logic [7:0]  lo = 8'h00;
  logic        fv;
  logic [7:0]  b0, b1, b2, i0, i1, i2, rc, sel;
  logic [7:0]  outs = 8'h19;
  logic        dly = 1'b1;
  logic [7:0]  cpl = 8'h00;
  logic        rq = 1'b0;
  logic [7:0]  svc = 8'h00;
  logic [7:0]  oa = 8'h00;
  logic [7:0]  ob = 8'h00;
  logic [7:0]  psel = 8'h00;
  logic        xe = 1'b0;
  logic        xo = 1'b0;
  logic        rv, re, busy, run;
  logic [15:0] rib;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;

  pgw_master_model i_pgw_master_model (.clk(clk), .send(send), .cmd(cmd),
    .hi(hi), .lo(lo), .frame_valid(fv), .byte0(b0), .byte1(b1),
    .byte2(b2));

  pgw_gateway i_pgw_gateway (.clk(clk), .rst(rst), .out_frame_valid(fv),
    .out_byte0(b0), .out_byte1(b1), .out_byte2(b2),
    .remote_output_bits(outs), .unit_has_delay(dly),
    .coupling_status(cpl), .req_valid(rq), .req_service(svc),
    .req_object_a(oa), .req_object_b(ob), .parameter_selector(psel),
    .xchg_end(xe), .xchg_ok(xo), .rsp_valid(rv), .rsp_code(rc),
    .rsp_error(re), .cmd_busy(busy), .cmd_selector(sel), .in_byte0(i0),
    .in_byte1(i1), .in_byte2(i2), .remote_input_bits(rib),
    .run_mode(run));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      n_mismatch++;
    end
  endtask

  task automatic put(input logic [7:0] c, a, b);
    @(posedge clk);
    send <= 1'b1;
    cmd <= c;
    hi <= a;
    lo <= b;
    @(posedge clk);
    send <= 1'b0;
  endtask

  task automatic frame(input logic [7:0] c, a, b, input logic [15:0] e,
                       input logic r);
    put(c, a, b);
    repeat (3) @(posedge clk);
    #1;
    chk("remote_input_bits", e, rib);
    chk("run_mode", {15'h0, r}, {15'h0, run});
    chk("in_byte0 run", {15'h0, r}, {15'h0, i0[0]});
  endtask

  task automatic status();
    #1;
    chk("reset inputs", 16'h0000, rib);
    chk("in_byte0 delay", 16'h0020, {8'h00, i0});
    chk("in_byte1", 16'h0019, {8'h00, i1});
    chk("in_byte2", 16'h0000, {8'h00, i2});
    @(posedge clk);
    dly <= 1'b0;
    cpl <= `PGW_STATUS_BAD;
    repeat (2) @(posedge clk);
    #1;
    chk("in_byte0 nodelay", 16'h0010, {8'h00, i0});
    chk("in_byte1 bad", 16'h0000, {8'h00, i1});
    cpl <= 8'h00;
  endtask

  task automatic request(input logic [7:0] s, b);
    @(posedge clk);
    rq <= 1'b1;
    svc <= s;
    oa <= `PGW_OBJ_A;
    ob <= b;
    psel <= 8'h93;
    @(posedge clk);
    rq <= 1'b0;
    #1;
  endtask

  task automatic bad(input logic [7:0] s, b);
    request(s, b);
    chk("bad rsp_valid", 16'h0001, {15'h0, rv});
    chk("bad rsp_code", {8'h00, `PGW_RESP_REJECT}, {8'h00, rc});
    chk("bad rsp_error", 16'h0001, {15'h0, re});
    @(posedge clk);
  endtask

  task automatic explicit_cmd();
    request(`PGW_SVC_CODE, `PGW_OBJ_B);
    chk("cmd_busy", 16'h0001, {15'h0, busy});
    outs <= 8'h66;
    dly <= 1'b1;
    put(`PGW_CMD_VALID, 8'h0F, 8'hF0);
    repeat (4) @(posedge clk);
    #1;
    chk("held inputs", 16'h0000, rib);
    chk("held in_byte1", 16'h0019, {8'h00, i1});
    chk("held in_byte0", 16'h0010, {8'h00, i0});
    xe <= 1'b1;
    xo <= 1'b1;
    @(posedge clk);
    xe <= 1'b0;
    #1;
    chk("rsp_valid", 16'h0001, {15'h0, rv});
    chk("rsp_code", {8'h00, `PGW_RESP_OK}, {8'h00, rc});
    chk("rsp_error", 16'h0000, {15'h0, re});
    chk("cmd_selector", 16'h0093, {8'h00, sel});
    repeat (3) @(posedge clk);
    #1;
    chk("late inputs", 16'h0FF0, rib);
    chk("late in_byte1", 16'h0066, {8'h00, i1});
    chk("late in_byte0", 16'h0020, {8'h00, i0});
  endtask

  task automatic failed_cmd();
    request(`PGW_SVC_CODE, `PGW_OBJ_B);
    xe <= 1'b1;
    xo <= 1'b0;
    @(posedge clk);
    xe <= 1'b0;
    #1;
    chk("fail rsp_valid", 16'h0001, {15'h0, rv});
    chk("fail rsp_code", {8'h00, `PGW_RESP_REJECT}, {8'h00, rc});
    chk("fail rsp_error", 16'h0001, {15'h0, re});
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    status();
    frame(`PGW_CMD_VALID, 8'hAA, 8'h55, 16'hAA55, 1'b0);
    frame(`PGW_CMD_RUN, 8'h11, 8'h22, 16'hAA55, 1'b1);
    frame(8'h55, 8'h33, 8'h44, 16'hAA55, 1'b1);
    frame(`PGW_CMD_STOP, 8'h66, 8'h77, 16'hAA55, 1'b0);
    frame(`PGW_CMD_VALID, 8'h19, 8'h2B, 16'h192B, 1'b0);
    frame(`PGW_CMD_SAFE, 8'hFF, 8'hFF, 16'h0000, 1'b0);
    explicit_cmd();
    failed_cmd();
    bad(8'h33, `PGW_OBJ_B);
    bad(`PGW_SVC_CODE, 8'h02);
    conclude();
  end
endmodule
